// ---- cell_monitor_map.svh ----
/*
 Group lengths, field positions, reset values and command codes of the cell
 monitor register bank. Included by the design files; defines only.
*/
`ifndef CELL_MONITOR_MAP_SVH
`define CELL_MONITOR_MAP_SVH

// Command codes sent by the host as the first byte of a frame
`define CMD_WRITE_CFG 8'h01
`define CMD_READ_CFG 8'h02
`define CMD_READ_CV 8'h04
`define CMD_READ_FLG 8'h06

// Group lengths in bytes
`define CFG_BYTES 5'd6
`define CV_BYTES 5'd18
`define CV_BYTES_TEN 5'd15
`define FLG_BYTES 5'd3

// Cell count and result width
`define NUM_CELLS 12
`define RESULT_W 12

// Configuration byte 0 field positions
`define CFG0_WATCHDOG 7
`define CFG0_GPIO2 6
`define CFG0_GPIO1 5
`define CFG0_POLL 4
`define CFG0_TEN 3
`define CFG0_DUTY_HI 2
`define CFG0_DUTY_LO 0

// Configuration byte 2 split: masks above, discharge enables below
`define CFG2_MASK_LO 4
`define CFG2_DIS_HI 3

// Reset values: both general pin pull-downs off
`define CFG0_RESET 8'h60
`define CFGX_RESET 8'h00

`endif

// ---- cell_monitor_pkg.sv ----
/*
 Types shared by the cell monitor register bank.
 Assumes nothing of its surroundings.
*/
package cell_monitor_pkg;

    // Frame handling states, one-hot
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_READ = 4'b0100,
        ST_SKIP = 4'b1000
    } link_state_e;

    // Register group being read
    typedef enum logic [1:0]
    {
        GRP_CFG = 2'h0,
        GRP_CV = 2'h1,
        GRP_FLG = 2'h2,
        GRP_NONE = 2'h3
    } group_e;

endpackage

// ---- cell_monitor_regs.sv ----
/*
 Register bank of a multi-cell battery monitor: configuration group,
 packed cell result group and cell flag group, reached by command codes
 arriving as whole bytes from the serial front end.
 Assumes the serial shifter, converter and comparators sit outside on
 the same clock and hand over bytes, results and flags as plain levels.
*/
`timescale 1ns/1ps
`include "cell_monitor_map.svh"

module cell_monitor_regs
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Byte stream from the serial front end
    input wire logic frame_active,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    // Converter results and comparator flags, cell 1 lowest
    input wire logic [`NUM_CELLS*`RESULT_W-1:0] cell_results,
    input wire logic [`NUM_CELLS-1:0] under_flags,
    input wire logic [`NUM_CELLS-1:0] over_flags,
    // General pins, open-drain pull-downs
    input wire logic gpio1_in,
    output logic gpio1_out,
    output logic gpio1_oe_n,
    input wire logic gpio2_in,
    output logic gpio2_out,
    output logic gpio2_oe_n,
    // Configuration and cell alarm toward the rest of the device
    output logic watchdog_flag,
    output logic poll_style_select,
    output logic ten_cell_select,
    output logic [2:0] comparator_duty_code,
    output logic [`NUM_CELLS-1:0] discharge_enable,
    output logic [7:0] undervoltage_threshold,
    output logic [7:0] overvoltage_threshold,
    output logic cell_alarm
);

    // Six whole bytes, so a write is one store
    // by position; field outputs pick their bits
    // out of these bytes.
    // Configuration storage, one byte per entry
    logic [7:0] cfg_ff [0:5];

    // Frame handling
    cell_monitor_pkg::link_state_e state_ff;
    cell_monitor_pkg::link_state_e nxt_state;
    cell_monitor_pkg::group_e group_ff;
    cell_monitor_pkg::group_e nxt_group;
    logic [4:0] idx_ff; // Byte position within the group
    logic [4:0] nxt_idx;
    logic [7:0] tx_byte_ff; // Byte offered to the host
    logic [7:0] nxt_tx_byte;
    logic alarm_ff; // Unmasked flag summary

    // Read-side views
    logic [7:0] cv_byte [0:17]; // Packed result bytes
    logic [7:0] cfg_rd [0:5]; // Config bytes as read back
    logic [23:0] flag_bits; // All flags, cell 1 in bits 1:0
    logic [7:0] flg_rd [0:2];
    logic [1:0] pin_level; // Synchronised pin levels
    logic [4:0] group_len; // Length of the selected group
    logic [4:0] rd_idx; // Index of the byte to load next
    logic cmd_take; // Command byte accepted this cycle
    logic rx_take; // Byte accepted this cycle, command or data
    logic [`NUM_CELLS-1:0] irq_mask;
    logic [`NUM_CELLS-1:0] live_cells;

    // Pins live outside this clock. A level is
    // four edges old when the bank sees it, so a
    // read just after a pull-down change still
    // shows the old level.
    // Both pins go through the same three-stage filter
    pin_sync #(.W(2)) u_pin_sync
    (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .pin_in({gpio2_in, gpio1_in}),
        .level(pin_level)
    );

    // Packing is combinational and a byte is
    // captured only when loaded, so a result
    // that moves mid-frame can tear across the
    // three bytes of its pair.
    // One packer per cell pair; bytes ascend with cell number
    for (genvar p = 0; p < `NUM_CELLS/2; p++)
    begin : g_pair
        pair_pack_if pif();
        cell_pair_pack u_pack
        (
            .bus(pif.pack)
        );
        assign pif.odd_res = cell_results[(2*p)*`RESULT_W +: `RESULT_W];
        assign pif.even_res = cell_results[(2*p+1)*`RESULT_W +: `RESULT_W];
        assign cv_byte[3*p] = pif.bytes[7:0];
        assign cv_byte[3*p+1] = pif.bytes[15:8];
        assign cv_byte[3*p+2] = pif.bytes[23:16];
    end

    // Hiding cells 11 and 12 here, ahead of both
    // the flag bytes and the alarm, keeps the
    // two views in agreement.
    // Flags interleaved per cell: under at even bit, over at odd bit
    for (genvar c = 0; c < `NUM_CELLS; c++)
    begin : g_flag
        // Cells 11 and 12 are held low in ten-cell mode
        assign live_cells[c] = (c < 10) || !cfg_ff[0][`CFG0_TEN];
        assign flag_bits[2*c] = under_flags[c] & live_cells[c];
        assign flag_bits[2*c+1] = over_flags[c] & live_cells[c];
    end

    // Flag bytes: byte 2 carries cells 9, 10 low and 11, 12 high
    assign flg_rd[0] = flag_bits[7:0];
    assign flg_rd[1] = flag_bits[15:8];
    assign flg_rd[2] = flag_bits[23:16];

    // Config readback: pin bits show the pin, not the stored control
    assign cfg_rd[0] = {cfg_ff[0][`CFG0_WATCHDOG], pin_level[1], pin_level[0],
                        cfg_ff[0][4:0]};
    assign cfg_rd[1] = cfg_ff[1];
    assign cfg_rd[2] = cfg_ff[2];
    assign cfg_rd[3] = cfg_ff[3];
    assign cfg_rd[4] = cfg_ff[4];
    assign cfg_rd[5] = cfg_ff[5];

    // Only the first byte of a frame is a command;
    // later bytes are write data or shift bytes.
    // A byte while the frame is closed is dropped.
    assign cmd_take = (state_ff == cell_monitor_pkg::ST_IDLE) && frame_active && rx_valid;
    assign rx_take = frame_active && rx_valid;

    // Decode the command byte into the group it reads
    always_comb
    begin
        nxt_group = group_ff;
        if (cmd_take)
        begin
            case (rx_byte)
                `CMD_READ_CFG: nxt_group = cell_monitor_pkg::GRP_CFG;
                `CMD_READ_CV: nxt_group = cell_monitor_pkg::GRP_CV;
                `CMD_READ_FLG: nxt_group = cell_monitor_pkg::GRP_FLG;
                default: nxt_group = cell_monitor_pkg::GRP_NONE;
            endcase
        end
    end

    // Built from the group about to be chosen, so
    // the length is right in the command cycle.
    // Group length; ten-cell mode cuts the results before cell 11
    always_comb
    begin
        case (nxt_group)
            cell_monitor_pkg::GRP_CFG: group_len = `CFG_BYTES;
            cell_monitor_pkg::GRP_CV:
                group_len = cfg_ff[0][`CFG0_TEN] ? `CV_BYTES_TEN : `CV_BYTES;
            cell_monitor_pkg::GRP_FLG: group_len = `FLG_BYTES;
            default: group_len = 5'h00;
        endcase
    end

    // Next byte to present: first of the group on a command, else the following one
    assign rd_idx = cmd_take ? 5'h00 : 5'(idx_ff + 5'h01);

    // Zero past the end instead of wrapping: an
    // over-read shows a blank, not byte 0 again.
    // Byte fetch; past the end of a group the line carries zero
    always_comb
    begin
        nxt_tx_byte = 8'h00;
        if (rd_idx < group_len)
        begin
            case (nxt_group)
                cell_monitor_pkg::GRP_CFG: nxt_tx_byte = cfg_rd[rd_idx[2:0]];
                cell_monitor_pkg::GRP_CV: nxt_tx_byte = cv_byte[rd_idx];
                cell_monitor_pkg::GRP_FLG: nxt_tx_byte = flg_rd[rd_idx[1:0]];
                default: nxt_tx_byte = 8'h00;
            endcase
        end
    end

    // Unknown codes park in the skip state, so the
    // rest of the frame is never taken as a command.
    // Frame state: the first byte of a frame is the command
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            cell_monitor_pkg::ST_IDLE:
            begin
                if (cmd_take)
                begin
                    if (rx_byte == `CMD_WRITE_CFG)
                        nxt_state = cell_monitor_pkg::ST_WRITE;
                    else if (nxt_group != cell_monitor_pkg::GRP_NONE)
                        nxt_state = cell_monitor_pkg::ST_READ;
                    else
                        nxt_state = cell_monitor_pkg::ST_SKIP;
                end
            end
            cell_monitor_pkg::ST_WRITE,
            cell_monitor_pkg::ST_READ,
            cell_monitor_pkg::ST_SKIP:
            begin
                // Every command ends with its frame
                if (!frame_active)
                    nxt_state = cell_monitor_pkg::ST_IDLE;
            end
            default: nxt_state = cell_monitor_pkg::ST_IDLE;
        endcase
    end

    // Saturating at the end means a long run of
    // shift bytes cannot wrap into valid data.
    // Byte position: reset per command, stops at the group end
    always_comb
    begin
        nxt_idx = idx_ff;
        if (cmd_take)
            nxt_idx = 5'h00;
        else if (rx_take && state_ff == cell_monitor_pkg::ST_WRITE && idx_ff < `CFG_BYTES)
            nxt_idx = 5'(idx_ff + 5'h01);
        else if (rx_take && state_ff == cell_monitor_pkg::ST_READ && idx_ff < group_len)
            nxt_idx = 5'(idx_ff + 5'h01);
    end

    // State, group and position registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_ff <= cell_monitor_pkg::ST_IDLE;
            group_ff <= cell_monitor_pkg::GRP_NONE;
            idx_ff <= 5'h00;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            group_ff <= nxt_group;
            idx_ff <= nxt_idx;
        end
    end

    // A registered byte stays steady for the
    // whole time the shifter takes to send it.
    // Outgoing byte: loaded on the command and after each shifted byte
    always_ff @(posedge clk)
    begin
        if (reset)
            tx_byte_ff <= 8'h00;
        else if (ce)
        begin
            if (cmd_take || (rx_take && state_ff == cell_monitor_pkg::ST_READ))
                tx_byte_ff <= nxt_tx_byte;
            else if (!frame_active)
                tx_byte_ff <= 8'h00; // Nothing stale carries into the next frame
        end
    end

    // Configuration writes land byte by byte in arrival order.
    // A frame cut short keeps the bytes already received; there is no
    // checksum stage here to hold them back.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cfg_ff[0] <= `CFG0_RESET;
            for (int i = 1; i < 6; i++)
                cfg_ff[i] <= `CFGX_RESET;
        end
        else if (ce)
        begin
            if (rx_take && state_ff == cell_monitor_pkg::ST_WRITE && idx_ff < `CFG_BYTES)
                cfg_ff[idx_ff[2:0]] <= rx_byte;
        end
    end

    // A set mask hides that cell from the alarm
    // only; its flags still read back.
    // Masks sit in the top of byte 2 and all of byte 3
    assign irq_mask = {cfg_ff[3], cfg_ff[2][7:`CFG2_MASK_LO]};

    // Registered so comparator glitches never
    // reach the alarm as a runt pulse; costs
    // one cycle of delay.
    // Summary of unmasked out-of-range cells, registered
    always_ff @(posedge clk)
    begin
        if (reset)
            alarm_ff <= 1'b0;
        else if (ce)
            alarm_ff <= |((under_flags | over_flags) & live_cells & ~irq_mask);
    end

    // Combinational, so it drops in the cycle the
    // frame closes; no stale valid follows it.
    // Read handshake is offered while the group still has bytes
    assign tx_valid = (state_ff == cell_monitor_pkg::ST_READ) && (idx_ff < group_len)
                      && frame_active;
    assign tx_byte = tx_byte_ff;

    // Open-drain style: the value is always low
    // and only the enable moves, so the pin is
    // never driven high from here.
    // Pull-down drives low when its control bit is zero
    assign gpio1_out = 1'b0;
    assign gpio1_oe_n = cfg_ff[0][`CFG0_GPIO1];
    assign gpio2_out = 1'b0;
    assign gpio2_oe_n = cfg_ff[0][`CFG0_GPIO2];

    // Consumers see a new setting on the edge
    // after the byte that carries it.
    // Field outputs straight from the configuration flops
    assign watchdog_flag = cfg_ff[0][`CFG0_WATCHDOG];
    assign poll_style_select = cfg_ff[0][`CFG0_POLL];
    assign ten_cell_select = cfg_ff[0][`CFG0_TEN];
    assign comparator_duty_code = cfg_ff[0][`CFG0_DUTY_HI:`CFG0_DUTY_LO];
    assign discharge_enable = {cfg_ff[2][`CFG2_DIS_HI:0], cfg_ff[1]};
    assign undervoltage_threshold = cfg_ff[4];
    assign overvoltage_threshold = cfg_ff[5];
    assign cell_alarm = alarm_ff;

endmodule // cell_monitor_regs

// ---- cell_monitor_regs_properties.sv ----
/*
 Checker for the cell monitor register bank, watching top-level ports only.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module cell_monitor_regs_properties
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic frame_active,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic watchdog_flag,
    input wire logic poll_style_select,
    input wire logic ten_cell_select,
    input wire logic [2:0] comparator_duty_code,
    input wire logic [11:0] discharge_enable,
    input wire logic [7:0] undervoltage_threshold,
    input wire logic [7:0] overvoltage_threshold,
    input wire logic gpio1_oe_n
);
    logic taken; // Byte accepted at this edge
    logic in_ff; // Command byte already seen in this frame
    logic [7:0] cmd_ff; // Command of the open frame
    logic [4:0] idx_ff; // Bytes after the command; saturates so it cannot wrap
    logic [4:0] len_w; // Bytes the open command offers
    assign taken = ce && frame_active && rx_valid;
    // Frame tracker, cleared whenever the frame closes
    always_ff @(posedge clk)
    begin
        if (reset || (ce && !frame_active))
        begin
            in_ff <= 1'b0;
            idx_ff <= 5'h00;
        end
        else if (taken && !in_ff)
        begin
            in_ff <= 1'b1;
            cmd_ff <= rx_byte;
        end
        else if (taken && idx_ff != 5'h1f)
        begin
            idx_ff <= idx_ff + 5'h01;
        end
    end
    // Group length; writes and unknown codes offer nothing
    always_comb
    begin
        case (cmd_ff)
            8'h02: len_w = 5'h06;
            8'h04: len_w = ten_cell_select ? 5'h0f : 5'h12;
            8'h06: len_w = 5'h03;
            default: len_w = 5'h00;
        endcase
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Data byte k of a configuration write
    sequence wr_s(int k);
        taken && in_ff && cmd_ff == 8'h01 && idx_ff == k;
    endsequence
    cfg0_write_a: assert property (wr_s(0) |=>
        {watchdog_flag, poll_style_select, ten_cell_select, comparator_duty_code}
        == {$past(rx_byte[7]), $past(rx_byte[4:0])}) else $error("config byte 0 not taken");
    pull_ctl_a: assert property (wr_s(0) |=> gpio1_oe_n == $past(rx_byte[5]))
        else $error("pin 1 pull-down control wrong");
    disch_low_a: assert property (wr_s(1) |=> discharge_enable[7:0] == $past(rx_byte))
        else $error("discharge cells 1 to 8 wrong");
    disch_high_a: assert property (wr_s(2) |=> discharge_enable[11:8] == $past(rx_byte[3:0]))
        else $error("discharge cells 9 to 12 wrong");
    under_thr_a: assert property (wr_s(4) |=> undervoltage_threshold == $past(rx_byte))
        else $error("under threshold wrong");
    over_thr_a: assert property (wr_s(5) |=> overvoltage_threshold == $past(rx_byte))
        else $error("over threshold wrong");
    cfg_hold_a: assert property (!(taken && in_ff && cmd_ff == 8'h01) |=>
        $stable(undervoltage_threshold) && $stable(overvoltage_threshold)
        && $stable(discharge_enable)) else $error("config changed without a write");
    read_len_a: assert property (in_ff && frame_active |-> tx_valid == (idx_ff < len_w))
        else $error("offered byte count wrong");
    idle_quiet_a: assert property (!in_ff |-> !tx_valid && tx_byte == 8'h00)
        else $error("byte offered outside a read");
    past_end_a: assert property (in_ff && len_w != 0 && idx_ff >= len_w |-> tx_byte == 8'h00)
        else $error("byte past group end not zero");
endmodule // cell_monitor_regs_properties

bind cell_monitor_regs cell_monitor_regs_properties i_cell_monitor_regs_properties (.*);

// ---- cell_monitor_regs_tb_top.sv ----
/*
 Self-checking bench for the cell monitor register bank.
 Assumes the checker is bound by its own file and the host model drives bytes.
*/
`timescale 1ns/1ps

module cell_monitor_regs_tb_top;
    logic clk = 1'b0;
    logic reset; // Held for six cycles
    logic frame_active;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic [143:0] cell_results;
    logic [11:0] under;
    logic [11:0] over;
    logic ext1; // Level pin 1 floats to while nothing pulls it
    logic pin1;
    logic pin2;
    logic o1;
    logic o1_n;
    logic o2;
    logic o2_n;
    logic wdog;
    logic poll;
    logic ten;
    logic [2:0] duty;
    logic [11:0] dis;
    logic [7:0] uv_thr;
    logic [7:0] ov_thr;
    logic alarm; // Unmasked flag summary
    logic [11:0] cv [1:12]; // Cell results, cell 1 first
    logic [7:0] got [18];
    logic vld [18];
    logic [7:0] cfg_a [18] = '{0: 8'h07, 1: 8'h81, 2: 8'h5a, 3: 8'hc3, 4: 8'h3c,
        5: 8'hf0, default: 8'h00};
    logic [7:0] cfg_b [18] = '{default: 8'h28};
    int bad_count = 0;
    int compares = 0;
    always #5 clk = ~clk;
    // Open-drain pins: the pull-down wins over the outside level
    assign pin1 = o1_n ? ext1 : o1;
    assign pin2 = o2_n ? 1'b1 : o2;
    host_model i_host_model (.clk(clk), .frame_active(frame_active), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte));
    cell_monitor_regs i_cell_monitor_regs (.clk(clk), .reset(reset), .ce(1'b1),
        .frame_active(frame_active), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .cell_results(cell_results),
        .under_flags(under), .over_flags(over), .gpio1_in(pin1), .gpio1_out(o1),
        .gpio1_oe_n(o1_n), .gpio2_in(pin2), .gpio2_out(o2), .gpio2_oe_n(o2_n),
        .watchdog_flag(wdog), .poll_style_select(poll), .ten_cell_select(ten),
        .comparator_duty_code(duty), .discharge_enable(dis),
        .undervoltage_threshold(uv_thr), .overvoltage_threshold(ov_thr), .cell_alarm(alarm));
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // One whole frame: command then n bytes, each after gap idle cycles
    task automatic run(input logic [7:0] cmd, input logic [7:0] d [18], input int n,
        input int gap);
        logic [7:0] g;
        logic v;
        i_host_model.open_frame();
        i_host_model.xfer(cmd, gap, g, v);
        for (int i = 0; i < n; i++)
        begin
            i_host_model.xfer(d[i], gap, got[i], vld[i]);
        end
        i_host_model.close_frame();
        repeat (6) @(negedge clk); // Lets pin levels pass the synchroniser
    endtask
    function automatic logic [7:0] cv_exp(input int k);
        logic [11:0] o;
        logic [11:0] e;
        o = cv[2 * (k / 3) + 1];
        e = cv[2 * (k / 3) + 2];
        case (k % 3)
            0: return o[7:0];
            1: return {e[3:0], o[11:8]};
            default: return e[11:4];
        endcase
    endfunction
    function automatic logic [7:0] fl_exp(input int k, input logic t);
        logic [7:0] r;
        for (int i = 0; i < 4; i++)
        begin
            r[2 * i] = under[4 * k + i];
            r[2 * i + 1] = over[4 * k + i];
        end
        if (t && k == 2)
        begin
            r[7:4] = 4'h0; // Cells 11 and 12 hidden in ten-cell mode
        end
        return r;
    endfunction
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    initial
    begin
        reset = 1'b1;
        ext1 = 1'b1;
        under = 12'ha5c;
        over = 12'h3c6;
        for (int n = 1; n <= 12; n++)
        begin
            cv[n] = 12'h0a5 + 12'(n) * 12'h123;
            cell_results[(n - 1) * 12 +: 12] = cv[n];
        end
        repeat (6) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk); // Pin levels pass the filter
        run(8'h02, cfg_a, 6, 0);
        for (int i = 0; i < 6; i++) check("config reset", i ? 8'h00 : 8'h60, got[i]);
        run(8'h01, cfg_a, 6, 0);
        check("duty code", 8'h07, {5'h0, duty});
        check("discharge low", 8'h81, dis[7:0]);
        check("discharge high", 8'h0a, {4'h0, dis[11:8]});
        check("under threshold", 8'h3c, uv_thr);
        check("over threshold", 8'hf0, ov_thr);
        check("pin 1 enable", 8'h00, {7'h0, o1_n});
        run(8'h02, cfg_a, 6, 2);
        for (int i = 0; i < 6; i++) check("config readback", cfg_a[i], got[i]);
        // Partial write: pin 1 pull-down off, pin 2 pull-down on, pin 1 held low outside, ten-cell mode
        ext1 = 1'b0;
        run(8'h01, cfg_b, 1, 2);
        check("ten select", 8'h01, {7'h0, ten});
        check("pin 2 enable", 8'h00, {7'h0, o2_n});
        run(8'h02, cfg_a, 6, 0);
        for (int i = 0; i < 6; i++) check("config pin", i ? cfg_a[i] : 8'h08, got[i]);
        run(8'h04, cfg_a, 18, 0);
        for (int i = 0; i < 18; i++)
        begin
            check("ten cell byte", i < 15 ? cv_exp(i) : 8'h00, got[i]);
            check("ten cell valid", {7'h0, i < 15}, {7'h0, vld[i]});
        end
        run(8'h06, cfg_a, 3, 1);
        for (int i = 0; i < 3; i++) check("ten flags", fl_exp(i, 1'b1), got[i]);
        cfg_b[0] = 8'hf0;
        ext1 = 1'b1;
        run(8'h01, cfg_b, 1, 0);
        check("watchdog and poll", 8'h03, {6'h0, wdog, poll});
        run(8'h04, cfg_a, 18, 1);
        for (int i = 0; i < 18; i++) check("cell byte", cv_exp(i), got[i]);
        run(8'h06, cfg_a, 3, 0);
        for (int i = 0; i < 3; i++) check("flag byte", fl_exp(i, 1'b0), got[i]);
        run(8'h55, cfg_a, 2, 0);
        check("unknown command", 8'h00, {7'h0, vld[0] | vld[1]});
        under = 12'h005;
        over = 12'h830;
        repeat (2) @(negedge clk);
        check("alarm masked", 8'h00, {7'h0, alarm});
        under = 12'h00d;
        repeat (2) @(negedge clk);
        check("alarm unmasked", 8'h01, {7'h0, alarm});
        complete_run();
    end
endmodule // cell_monitor_regs_tb_top

// ---- cell_pair_pack.sv ----
/*
 Packs two 12-bit cell results into three bytes.
 Assumes the results are stable for the cycle in which they are read.
*/
`timescale 1ns/1ps

module cell_pair_pack
(
    pair_pack_if.pack bus
);

    // First: odd low byte; second: even low nibble over odd high nibble
    assign bus.bytes[7:0] = bus.odd_res[7:0];
    assign bus.bytes[15:8] = {bus.even_res[3:0], bus.odd_res[11:8]};
    assign bus.bytes[23:16] = bus.even_res[11:4];

endmodule // cell_pair_pack

// ---- host_model.sv ----
/*
 Host controller model on the byte side of the serial front end.
 Assumes the bench calls its tasks; it drives only at falling edges.
*/
`timescale 1ns/1ps

module host_model
(
    input wire logic clk,
    output logic frame_active,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte
);
    initial
    begin
        frame_active = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // Opens a frame; the opening cycle carries no byte
    task automatic open_frame();
        @(negedge clk);
        frame_active = 1'b1;
    endtask
    // Sends one byte after gap idle cycles, taking the byte offered meanwhile
    task automatic xfer(input logic [7:0] b, input int gap, output logic [7:0] got,
        output logic vld);
        repeat (gap)
        begin
            @(negedge clk);
            rx_valid = 1'b0;
            rx_byte = ~rx_byte; // Idle line never repeats the last byte
        end
        @(negedge clk);
        rx_valid = 1'b1;
        rx_byte = b;
        got = tx_byte;
        vld = tx_valid;
    endtask
    // Closes the frame; the bench reopens no sooner than one edge later
    task automatic close_frame();
        @(negedge clk);
        rx_valid = 1'b0;
        frame_active = 1'b0;
        rx_byte = ~rx_byte;
    endtask
endmodule // host_model

// ---- pair_pack_if.sv ----
/*
 Carrier between the bank and one result packer: two cell results in,
 three packed bytes out. Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`include "cell_monitor_map.svh"

interface pair_pack_if;
    logic [`RESULT_W-1:0] odd_res; // Lower-numbered cell of the pair
    logic [`RESULT_W-1:0] even_res; // Higher-numbered cell of the pair
    logic [23:0] bytes; // Packed bytes, first byte in bits 7:0

    modport src (output odd_res, output even_res, input bytes);
    modport pack (input odd_res, input even_res, output bytes);
endinterface

// ---- pin_sync.sv ----
/*
 Three-stage synchroniser for pin inputs; the output changes only once
 the second and third stages agree. Assumes inputs are asynchronous.
*/
`timescale 1ns/1ps

module pin_sync
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level
);

    logic [W-1:0] s1_ff; // Metastable stage, read only by s2
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] level_ff; // Filtered level

    // Shift chain, frozen with the clock enable
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end
        else if (ce)
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Accept a new level only when stages two and three agree
    always_ff @(posedge clk)
    begin
        if (reset)
            level_ff <= '0;
        else if (ce)
        begin
            for (int i = 0; i < W; i++)
            begin
                if (s2_ff[i] == s3_ff[i])
                    level_ff[i] <= s3_ff[i];
            end
        end
    end

    assign level = level_ff;

endmodule // pin_sync
